// >>> pkg/elk_pkg.sv
// shared constants and types of the egress lookup key builder
// ----------------------------------------
// How it works
// - edit ethernet frames with up to three tags
// - mpls: three tags, three labels, one word
// - identify frames by popped words and type
// - up to 60 bytes inserted if header stripped and no words popped
// - preamble takes 8 of those bytes
// - hardware clears ram init when done
// - one lookup per copy when enabled
// - cpu extraction frames: no edit, no lookup
// - lookup disabled: ignore all lookup actions
// - vid key on three conditions
// - service key only otherwise and enabled
// - key type bit: 0 service, 1 vid
// - egress port from per-port logical map
// - protection bit copied from header
// - switch instance: index, 0, or 0x3ff
// - class of service gated by port enable
// - colour from drop precedence map
// - service frame when index nonzero, enabled
// - service index field, service key only
// - vid field: vid, router leg or index
// - default action chosen by logical port
// ----------------------------------------
`default_nettype none
package elk_pkg;
	localparam logic [7:0] ADDR_LU_CTRL = 8'h00; // lookup control
	localparam logic [7:0] ADDR_RAM_CTRL = 8'h04; // ram init control
	localparam logic [7:0] ADDR_DROP_PRECEDENCE_MAP = 8'h08; // colour map
	localparam logic [7:0] ADDR_STATS = 8'h0C; // frame counters
	localparam logic [7:0] ADDR_PORT_BASE = 8'h40; // per-port table
	localparam int NUM_PORTS = 16; // config ports
	localparam int LU_ENA_BIT = 0;
	localparam int RLEG_BIT = 1;
	localparam int RTFWD_BIT = 2;
	localparam int CONFIG_RAM_ENABLE_BIT = 0;
	localparam int RAM_INIT_BIT = 1;
	localparam int PORT_SVC_BIT = 4;
	localparam logic [9:0] VSI_ROUTED = 10'h3FF; // routing marker
	localparam logic [2:0] MAX_TAGS = 3'h3;
	localparam logic [2:0] MAX_LABELS = 3'h3;
	localparam logic [6:0] PUSH_MAX_BYTES = 7'h3C; // 60
	localparam logic [6:0] PREAMBLE_BYTES = 7'h08; // 8
	localparam logic [3:0] DROP_PRECEDENCE_MAP_RST = 4'hC; // dp 2,3 yellow
	// destination forwarding modes
	typedef enum logic [1:0] {
		ELK_BRIDGE = 2'h0,
		ELK_UC_ROUTE = 2'h1,
		ELK_MC_ROUTE = 2'h2,
		ELK_OTHER = 2'h3
	} elk_destination_forward_mode_t;
	// internal frame header fields seen by the block
	typedef struct packed {
		logic [3:0] cfg_port;
		logic cpu_dst;
		elk_destination_forward_mode_t destination_forward_mode;
		logic routed_forward_flag;
		logic service_key_enable;
		logic protection_flag;
		logic [11:0] generic_index;
		logic generic_index_mode;
		logic [2:0] class_of_service_id;
		logic [1:0] drop_prec;
		logic [8:0] ingress_service_index;
		logic [11:0] vid;
		logic [11:0] egress_router_leg;
		logic [5:0] popped_word_count;
		logic [2:0] post_strip_frame_type;
		logic header_stripped;
		logic [2:0] vlan_tags;
		logic [2:0] mpls_labels;
		logic has_cw;
		logic inner_eth;
		logic [2:0] inner_tags;
	} elk_hdr_t;
	// lookup key
	typedef struct packed {
		logic key_type_field;
		logic [3:0] egress_port_field;
		logic protection_flag;
		logic [9:0] virtual_switch_instance;
		logic [2:0] class_of_service_id;
		logic color;
		logic service_frame_flag;
		logic [8:0] ingress_service_index;
		logic [11:0] vid;
	} elk_key_t;
	// per-copy descriptor towards match engine and action stage
	typedef struct packed {
		elk_key_t key;
		logic lookup_req;
		logic actions_enable;
		logic edit_allowed;
		logic [3:0] default_action_idx;
		logic [6:0] push_budget;
		logic [5:0] popped_word_count;
		logic [2:0] post_strip_frame_type;
	} elk_desc_t;
endpackage : elk_pkg
`default_nettype wire

// >>> core/elk_top.sv
// egress lookup key builder with apb register file
//
// The register addresses and register access over APB were chosen for this implementation.
`default_nettype none
module elk_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic hdr_valid,
	input wire elk_pkg::elk_hdr_t hdr,
	output logic hdr_ready,
	output logic desc_valid,
	output elk_pkg::elk_desc_t desc,
	input wire logic desc_ready
);
	import elk_pkg::*;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic lu_ena; // global lookup enable
	logic rleg_mode; // router_leg_key_mode
	logic rtfwd_mode; // routed_forward_key_mode
	logic config_ram_enable; // config_ram_enable
	logic ram_init; // init in progress
	logic [3:0] drop_precedence_map; // drop_precedence_map
	logic [3:0] lport [NUM_PORTS]; // logical_port_map
	logic svc_en [NUM_PORTS]; // port_service_index_enable
	logic [15:0] frame_cnt; // copies handled
	logic [15:0] lookup_cnt; // lookups issued
	logic [3:0] init_idx; // init walk pointer

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic acc; // access phase, first cycle
	logic wr; // write takes effect
	logic port_hit; // address in port table
	logic [3:0] port_sel; // port table index
	logic mapped; // address is decoded

	assign acc = psel & penable & ~pready;
	assign wr = acc & pwrite;
	assign port_hit = (paddr[7:6] == ADDR_PORT_BASE[7:6]) && (paddr[1:0] == 2'h0);
	assign port_sel = paddr[5:2];
	assign mapped = port_hit || paddr == ADDR_LU_CTRL || paddr == ADDR_RAM_CTRL
		|| paddr == ADDR_DROP_PRECEDENCE_MAP || paddr == ADDR_STATS;

	// ready one cycle into access, drop after
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= acc;
		end
	end

	// read data and error registered with ready
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (acc) begin
			pslverr <= ~mapped;
			prdata <= 32'h0000_0000;
			if (!pwrite) begin
				if (port_hit) begin
					prdata <= {27'h0, svc_en[port_sel], lport[port_sel]};
				end else if (paddr == ADDR_LU_CTRL) begin
					prdata <= {29'h0, rtfwd_mode, rleg_mode, lu_ena};
				end else if (paddr == ADDR_RAM_CTRL) begin
					prdata <= {30'h0, ram_init, config_ram_enable};
				end else if (paddr == ADDR_DROP_PRECEDENCE_MAP) begin
					prdata <= {28'h0, drop_precedence_map};
				end else if (paddr == ADDR_STATS) begin
					prdata <= {lookup_cnt, frame_cnt};
				end
			end
		end
	end

	// lookup control register
	always_ff @(posedge clk) begin
		if (rst) begin
			lu_ena <= 1'b0;
			rleg_mode <= 1'b0;
			rtfwd_mode <= 1'b0;
		end else if (wr && paddr == ADDR_LU_CTRL) begin
			lu_ena <= pwdata[LU_ENA_BIT];
			rleg_mode <= pwdata[RLEG_BIT];
			rtfwd_mode <= pwdata[RTFWD_BIT];
		end
	end

	// colour map register
	always_ff @(posedge clk) begin
		if (rst) begin
			drop_precedence_map <= DROP_PRECEDENCE_MAP_RST;
		end else if (wr && paddr == ADDR_DROP_PRECEDENCE_MAP) begin
			drop_precedence_map <= pwdata[3:0];
		end
	end

	// ----------------------------------------
	// ram enable and initialisation
	// ----------------------------------------
	logic init_done; // last entry written
	logic init_set; // software start
	assign init_done = ram_init && config_ram_enable && init_idx == 4'(NUM_PORTS - 1);
	assign init_set = wr && paddr == ADDR_RAM_CTRL && pwdata[RAM_INIT_BIT];

	// enable bit; init only runs while enabled
	always_ff @(posedge clk) begin
		if (rst) begin
			config_ram_enable <= 1'b0;
		end else if (wr && paddr == ADDR_RAM_CTRL) begin
			config_ram_enable <= pwdata[CONFIG_RAM_ENABLE_BIT];
		end
	end

	// init flag: software sets, hardware clears, set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			ram_init <= 1'b0;
		end else if (init_set) begin
			ram_init <= 1'b1;
		end else if (init_done) begin
			ram_init <= 1'b0;
		end
	end

	// walk pointer over the port table
	always_ff @(posedge clk) begin
		if (rst) begin
			init_idx <= 4'h0;
		end else if (init_set || init_done) begin
			init_idx <= 4'h0;
		end else if (ram_init && config_ram_enable) begin
			init_idx <= init_idx + 4'h1;
		end
	end

	// per-port table: identity map after init
	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			always_ff @(posedge clk) begin
				if (rst) begin
					lport[p] <= 4'(p);
					svc_en[p] <= 1'b0;
				end else if (ram_init && config_ram_enable && init_idx == 4'(p)) begin
					lport[p] <= 4'(p);
					svc_en[p] <= 1'b0;
				end else if (wr && port_hit && port_sel == 4'(p)) begin
					lport[p] <= pwdata[3:0];
					svc_en[p] <= pwdata[PORT_SVC_BIT];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// key assembly
	// ----------------------------------------
	logic routed_rleg; // router-leg routing case
	logic routed_fwd; // routed-forward case
	logic use_vid; // vid key chosen
	logic do_lookup; // lookup for this copy
	logic psvc; // port service enable
	logic fmt_ok; // frame format editable
	logic no_pop; // only header stripped
	elk_desc_t next_desc; // descriptor to register

	assign psvc = svc_en[hdr.cfg_port];
	assign routed_rleg = rleg_mode
		&& (hdr.destination_forward_mode == ELK_UC_ROUTE || hdr.destination_forward_mode == ELK_MC_ROUTE);
	assign routed_fwd = rtfwd_mode && hdr.routed_forward_flag;
	assign use_vid = ~hdr.service_key_enable | routed_rleg | routed_fwd;
	assign do_lookup = lu_ena && !hdr.cpu_dst;
	assign no_pop = hdr.header_stripped && hdr.popped_word_count == 6'h00;

	// supported stack depths
	always_comb begin
		fmt_ok = hdr.vlan_tags <= MAX_TAGS;
		if (hdr.mpls_labels != 3'h0) begin
			fmt_ok = fmt_ok && hdr.mpls_labels <= MAX_LABELS;
			if (hdr.inner_eth) begin
				fmt_ok = fmt_ok && hdr.inner_tags <= MAX_TAGS;
			end
		end
	end

	// build the key and descriptor
	always_comb begin
		next_desc = '0;
		next_desc.key.key_type_field = use_vid;
		next_desc.key.egress_port_field = lport[hdr.cfg_port];
		next_desc.key.protection_flag = hdr.protection_flag;
		if (routed_rleg || routed_fwd) begin
			next_desc.key.virtual_switch_instance = VSI_ROUTED;
		end else if (hdr.generic_index_mode) begin
			next_desc.key.virtual_switch_instance = hdr.generic_index[9:0];
		end
		next_desc.key.class_of_service_id = psvc ? hdr.class_of_service_id : 3'h0;
		next_desc.key.color = drop_precedence_map[hdr.drop_prec];
		next_desc.key.service_frame_flag = psvc && hdr.ingress_service_index != 9'h000;
		if (!use_vid && psvc) begin
			next_desc.key.ingress_service_index = hdr.ingress_service_index;
		end
		if (use_vid) begin
			if (routed_rleg) begin
				next_desc.key.vid = hdr.egress_router_leg;
			end else if (routed_fwd) begin
				next_desc.key.vid = hdr.generic_index;
			end else begin
				next_desc.key.vid = hdr.vid;
			end
		end
		next_desc.lookup_req = do_lookup;
		next_desc.actions_enable = do_lookup;
		next_desc.edit_allowed = fmt_ok && !hdr.cpu_dst;
		next_desc.default_action_idx = lport[hdr.cfg_port];
		if (no_pop && !hdr.cpu_dst) begin
			next_desc.push_budget = PUSH_MAX_BYTES - PREAMBLE_BYTES;
		end
		next_desc.popped_word_count = hdr.popped_word_count;
		next_desc.post_strip_frame_type = hdr.post_strip_frame_type;
	end

	// ----------------------------------------
	// output handshake
	// ----------------------------------------
	logic take; // header accepted
	logic next_valid; // output slot full next
	assign take = hdr_valid && hdr_ready;
	assign next_valid = take || (desc_valid && !desc_ready);

	// descriptor slot held until accepted
	always_ff @(posedge clk) begin
		if (rst) begin
			desc_valid <= 1'b0;
			desc <= '0;
		end else begin
			desc_valid <= next_valid;
			if (take) begin
				desc <= next_desc;
			end
		end
	end

	// accept only into an empty slot, not during init
	always_ff @(posedge clk) begin
		if (rst) begin
			hdr_ready <= 1'b0;
		end else begin
			hdr_ready <= !next_valid && !(ram_init && !init_done) && !init_set;
		end
	end

	// counters, wrap around
	always_ff @(posedge clk) begin
		if (rst) begin
			frame_cnt <= 16'h0000;
			lookup_cnt <= 16'h0000;
		end else if (take) begin
			frame_cnt <= frame_cnt + 16'h0001;
			if (do_lookup) begin
				lookup_cnt <= lookup_cnt + 16'h0001;
			end
		end
	end
endmodule : elk_top
`default_nettype wire

// >>> dv/elk_engine_model.sv
// match engine stand-in that takes descriptors
`default_nettype none
module elk_engine_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic desc_valid,
	output logic desc_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] wait_cnt; // stall phase
	// free phase counter for slow acceptance
	always_ff @(posedge clk) begin
		if (rst) wait_cnt <= 2'h0;
		else wait_cnt <= wait_cnt + 2'h1;
	end
	// slow mode accepts one cycle in four
	assign desc_ready = desc_valid && (!slow || wait_cnt == 2'h3);
endmodule : elk_engine_model
`default_nettype wire

// >>> dv/elk_sva.sv
// port checker of the lookup key builder
`default_nettype none
module elk_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic hdr_valid,
	input wire elk_pkg::elk_hdr_t hdr,
	input wire logic hdr_ready,
	input wire logic desc_valid,
	input wire elk_pkg::elk_desc_t desc,
	input wire logic desc_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	import elk_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// header handed over
	sequence take_s;
		hdr_valid && hdr_ready;
	endsequence
	apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
	desc_hold_a: assert property (desc_valid && !desc_ready |=> desc_valid && $stable(desc))
		else $error("descriptor not held");
	take_answer_a: assert property (take_s |=> desc_valid && !hdr_ready) else $error("no descriptor");
	full_refuse_a: assert property (desc_valid |-> !hdr_ready) else $error("ready while full");
	cpu_skip_a: assert property (take_s and hdr.cpu_dst |=> !desc.lookup_req && !desc.edit_allowed)
		else $error("cpu frame looked up");
	vid_select_a: assert property (take_s and !hdr.service_key_enable |=> desc.key.key_type_field)
		else $error("vid key not chosen");
	prot_copy_a: assert property (take_s |=> desc.key.protection_flag == $past(hdr.protection_flag))
		else $error("protection bit wrong");
	field_zero_a: assert property (desc_valid |-> (desc.key.key_type_field ?
		desc.key.ingress_service_index == 9'h000 : desc.key.vid == 12'h000)) else $error("absent field set");
endmodule : elk_sva
bind elk_top elk_sva chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.hdr_valid(hdr_valid), .hdr(hdr), .hdr_ready(hdr_ready), .desc_valid(desc_valid), .desc(desc),
	.desc_ready(desc_ready));
`default_nettype wire

// >>> dv/elk_top_test.sv
// bench of the egress lookup key builder
`default_nettype none
module elk_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	import elk_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic hdr_valid = 1'b0;
	elk_hdr_t hdr = '0;
	logic slow = 1'b0; // engine stalls
	wire logic pready, pslverr, hdr_ready, desc_valid, desc_ready;
	wire logic [31:0] prdata;
	wire elk_desc_t desc;
	int fail_count = 0;
	int checks = 0;
	int sent = 0; // headers taken
	int looked = 0; // lookups expected
	logic [2:0] lu = 3'h0; // lookup control mirror
	logic [3:0] dpm = DROP_PRECEDENCE_MAP_RST; // colour map mirror
	logic [4:0] pcfg [NUM_PORTS]; // port table mirror
	elk_hdr_t base;
	elk_hdr_t h;
	logic [31:0] rd;
	logic err;
	elk_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .hdr_valid(hdr_valid),
		.hdr(hdr), .hdr_ready(hdr_ready), .desc_valid(desc_valid), .desc(desc), .desc_ready(desc_ready));
	elk_engine_model eng_u (.clk(clk), .rst(rst), .slow(slow), .desc_valid(desc_valid), .desc_ready(desc_ready));
	initial forever #50 clk = ~clk;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
		checks++;
		if (exp !== got) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	// one apb transfer: an idle edge first, so psel is never lowered and raised in one step
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr, input string what);
		apb(1'b0, a, 32'h0);
		check(what, 128'({experr, exp}), 128'({err, rd}));
		$display("test %s done", what);
	endtask : rdchk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a == ADDR_LU_CTRL) lu = d[2:0];
		if (a == ADDR_DROP_PRECEDENCE_MAP) dpm = d[3:0];
		if (a >= ADDR_PORT_BASE) pcfg[(a - ADDR_PORT_BASE) >> 2] = d[4:0];
	endtask : wr
	// expected descriptor from header and mirrored settings
	function automatic elk_desc_t want(input elk_hdr_t x);
		elk_desc_t e;
		logic rl, rf, pe, vk;
		e = '0;
		pe = pcfg[x.cfg_port][4];
		rl = lu[1] && (x.destination_forward_mode == ELK_UC_ROUTE || x.destination_forward_mode == ELK_MC_ROUTE);
		rf = lu[2] && x.routed_forward_flag;
		vk = !x.service_key_enable || rl || rf;
		e.key.key_type_field = vk;
		e.key.egress_port_field = pcfg[x.cfg_port][3:0];
		e.key.protection_flag = x.protection_flag;
		e.key.virtual_switch_instance = (rl || rf) ? VSI_ROUTED : (x.generic_index_mode ? x.generic_index[9:0] : 10'h0);
		e.key.class_of_service_id = pe ? x.class_of_service_id : 3'h0;
		e.key.color = dpm[x.drop_prec];
		e.key.service_frame_flag = pe && (x.ingress_service_index != 9'h0);
		e.key.ingress_service_index = (!vk && pe) ? x.ingress_service_index : 9'h0;
		e.key.vid = !vk ? 12'h0 : (rl ? x.egress_router_leg : (rf ? x.generic_index : x.vid));
		e.lookup_req = lu[0] && !x.cpu_dst;
		e.actions_enable = e.lookup_req;
		e.edit_allowed = !x.cpu_dst && x.vlan_tags <= MAX_TAGS && x.mpls_labels <= MAX_LABELS
			&& (x.mpls_labels == 3'h0 || !x.inner_eth || x.inner_tags <= MAX_TAGS);
		e.default_action_idx = e.key.egress_port_field;
		e.push_budget = (x.header_stripped && x.popped_word_count == 6'h0 && !x.cpu_dst) ? 7'h34 : 7'h0;
		e.popped_word_count = x.popped_word_count;
		e.post_strip_frame_type = x.post_strip_frame_type;
		return e;
	endfunction : want
	// offer one header and compare the accepted descriptor
	task automatic send(input elk_hdr_t x, input string what);
		elk_desc_t e;
		e = want(x);
		sent++;
		looked += int'(e.lookup_req);
		hdr <= x;
		hdr_valid <= 1'b1;
		// offer held until taken
		do begin
			@(posedge clk);
		end while (hdr_ready !== 1'b1);
		hdr_valid <= 1'b0;
		// descriptor compared at the edge the engine takes it
		do begin
			@(posedge clk);
		end while (desc_valid !== 1'b1 || desc_ready !== 1'b1);
		check(what, 128'(e), 128'(desc));
		$display("test %s done", what);
	endtask : send
	initial begin
		#3000000;
		fail_count++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		foreach (pcfg[i]) pcfg[i] = 5'(i);
		base = '{cfg_port: 4'h5, vid: 12'h123, egress_router_leg: 12'h456, generic_index: 12'hABC,
			ingress_service_index: 9'h1A5, class_of_service_id: 3'h5, drop_prec: 2'h2, protection_flag: 1'b1,
			vlan_tags: 3'h2, popped_word_count: 6'h05, post_strip_frame_type: 3'h2, destination_forward_mode: ELK_BRIDGE, default: '0};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(ADDR_LU_CTRL, 32'h0, 1'b0, "lu_ctrl");
		rdchk(ADDR_DROP_PRECEDENCE_MAP, 32'hC, 1'b0, "drop_precedence_map");
		rdchk(ADDR_PORT_BASE + 8'h0C, 32'h3, 1'b0, "port_map");
		rdchk(8'h10, 32'h0, 1'b1, "unmapped");
		wr(ADDR_RAM_CTRL, 32'h1);
		wr(ADDR_RAM_CTRL, 32'h3);
		rdchk(ADDR_RAM_CTRL, 32'h3, 1'b0, "init_busy");
		for (int i = 0; i < 40 && rd[1] !== 1'b0; i++) apb(1'b0, ADDR_RAM_CTRL, 32'h0);
		check("init_clear", 128'(1'b0), 128'(rd[1]));
		h = base;
		send(h, "lookup_off");
		wr(ADDR_PORT_BASE + 8'h14, 32'h19);
		wr(ADDR_LU_CTRL, 32'h1);
		wr(ADDR_DROP_PRECEDENCE_MAP, 32'h5);
		h.service_key_enable = 1'b1;
		send(h, "service_key");
		h.cfg_port = 4'h2;
		send(h, "port_off");
		wr(ADDR_LU_CTRL, 32'h3);
		slow <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			h = base;
			h.service_key_enable = 1'b1;
			h.destination_forward_mode = elk_destination_forward_mode_t'(m);
			send(h, "route_mode");
		end
		slow <= 1'b0;
		wr(ADDR_LU_CTRL, 32'h5);
		h.routed_forward_flag = 1'b1;
		send(h, "routed_fwd");
		h.routed_forward_flag = 1'b0;
		h.generic_index_mode = 1'b1;
		send(h, "gen_index");
		h.cpu_dst = 1'b1;
		send(h, "cpu_port");
		h = base;
		h.header_stripped = 1'b1;
		h.popped_word_count = 6'h00;
		send(h, "budget");
		h.vlan_tags = 3'h4;
		send(h, "tag_depth");
		// mpls stacks: legal, inner too deep, labels too deep
		h.vlan_tags = 3'h3;
		h.mpls_labels = 3'h3;
		h.has_cw = 1'b1;
		h.inner_eth = 1'b1;
		h.inner_tags = 3'h3;
		send(h, "mpls_stack");
		h.inner_tags = 3'h4;
		send(h, "inner_depth");
		h.mpls_labels = 3'h4;
		h.inner_tags = 3'h0;
		send(h, "label_depth");
		rdchk(ADDR_STATS, {16'(looked), 16'(sent)}, 1'b0, "stats");
		tally_and_finish();
	end
endmodule : elk_top_test
`default_nettype wire
